// >>> rtl/rrse_pkg.sv
// Constants shared by the return/rotate/power-down execute block.
// Assumes a 14-bit instruction word and an 8-bit file register path.
package rrse_pkg;
  // ------------------------------------------------------------
  // Instruction encodings
  // ------------------------------------------------------------
  localparam logic [13:0] OP_RETURN     = 14'h0008;
  localparam logic [13:0] OP_POWERDOWN  = 14'h0063;
  localparam logic [5:0]  OP_ROT_RIGHT  = 6'h0c;
  localparam logic [5:0]  OP_ROT_LEFT   = 6'h0d;
  localparam int          OPC_HI        = 13;
  localparam int          OPC_LO        = 8;
  localparam int          DEST_BIT      = 7;
  localparam int          FADDR_HI      = 6;
  localparam logic        DEST_W        = 1'b0;
  localparam logic        DEST_F        = 1'b1;
  // Return takes this many instruction cycles
  localparam int          RETURN_CYCLES = 2;
  localparam logic [7:0]  WDT_CLEARED   = 8'h00;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [3:0]  ADDR_CTRL   = 4'h0;
  localparam logic [3:0]  ADDR_FLAGS  = 4'h4;
  localparam logic [3:0]  ADDR_STAT   = 4'h8;
  localparam int          CTRL_ENABLE = 0;
  localparam int          CTRL_WAKE   = 1;
  localparam int          FLAG_CARRY  = 0;
  localparam int          FLAG_PD     = 1;
  localparam int          FLAG_TO     = 2;
  localparam int          STAT_SLEEP  = 0;
  localparam int          STAT_BUSY   = 1;
  localparam int          STAT_UNKN   = 2;
  localparam logic        CTRL_ENABLE_RST = 1'b1;
  localparam logic [2:0]  FLAGS_RST       = 3'h6;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RRSE_RUN   = 2'b00,
    RRSE_RET2  = 2'b01,
    RRSE_SLEEP = 2'b10
  } rrse_state_t;
endpackage

// >>> rtl/rrse_core.sv
// Execute logic for subroutine return, rotates through carry and
// power-down, with an AXI4-Lite register slave.
// Assumes combinational file register reads and a stack that pops on a
// one-cycle pulse while presenting its top entry at all times.
//
// Summary of operation
// - Return opcode pops the stack and loads the top entry into PC.
// - Return takes two cycles and leaves all flags alone.
// - Right rotate opcode carries one destination bit and 7-bit address.
// - Right rotate: carry into bit 7, bit 0 into carry, one cycle.
// - Destination 0 writes working register, 1 writes the file register.
// - Left rotate: carry into bit 0, bit 7 into carry.
// - Power-down clears the power-down flag and sets the expiry flag.
// - Power-down pulses watchdog_clear for one cycle to clear the watchdog counter.
// - After one cycle power-down enters sleep with oscillator halted.
`timescale 1ns/1ps
module rrse_core (
  input  wire logic                 clock,
  input  wire logic                 resetn,
  // Instruction stream
  input  wire logic                 instr_valid,
  input  wire logic [13:0]          instr_word,
  output logic                      instr_ready,
  // File register and working register
  output logic [6:0]                file_addr,
  input  wire logic [7:0]           file_rdata,
  output logic                      file_we,
  output logic [7:0]                file_wdata,
  output logic                      w_we,
  output logic [7:0]                w_wdata,
  // Stack and program counter
  input  wire logic [12:0]          stack_top_entry,
  output logic                      stack_pop,
  output logic                      pc_load,
  output logic [12:0]               pc_value,
  // Watchdog, sleep and wake
  output logic                      watchdog_clear,
  output logic                      sleep_mode,
  output logic                      osc_halt,
  input  wire logic                 wake_event,
  // AXI4-Lite slave
  input  wire logic [3:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [3:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);
  import rrse_pkg::*;

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic       rst_meta;
  logic       rst_n;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Rotate through carry, dir 1 = left
  function automatic logic [8:0] rotate(input logic [7:0] v,
                                        input logic c,
                                        input logic left);
    if (left) begin
      rotate = {v[7], v[6:0], c};
    end else begin
      rotate = {v[0], c, v[7:1]};
    end
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  rrse_state_t state;
  rrse_state_t next_state;
  logic        ctrl_enable;
  logic        carry;
  logic        powerdown_flag;
  logic        watchdog_expiry_flag;
  logic        unknown_seen;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire        take      = instr_valid && instr_ready;
  wire [5:0]  opc       = instr_word[OPC_HI:OPC_LO];
  wire        is_ret    = instr_word == OP_RETURN;
  wire        is_pdown  = instr_word == OP_POWERDOWN;
  wire        is_rrot   = opc == OP_ROT_RIGHT;
  wire        is_lrot   = opc == OP_ROT_LEFT;
  wire        is_rot    = is_rrot || is_lrot;
  wire        dest      = instr_word[DEST_BIT];
  wire [8:0]  rot_res   = rotate(file_rdata, carry, is_lrot);
  wire        do_rot    = take && is_rot;
  wire        do_ret    = take && is_ret;
  wire        do_pdown  = take && is_pdown;
  wire        do_unknown = take && !is_rot && !is_ret && !is_pdown;

  assign instr_ready = ctrl_enable && (state == RRSE_RUN);
  assign file_addr   = instr_word[FADDR_HI:0];
  assign osc_halt    = sleep_mode;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  wire         wr_go      = aw_held && w_held && !s_axi_bvalid;
  wire         wr_ctrl    = wr_go && (aw_addr == ADDR_CTRL) && w_strb[0];
  wire         wr_flags   = wr_go && (aw_addr == ADDR_FLAGS) && w_strb[0];
  wire         wr_mapped  = (aw_addr == ADDR_CTRL) ||
                            (aw_addr == ADDR_FLAGS) ||
                            (aw_addr == ADDR_STAT);
  wire         sw_wake    = wr_ctrl && w_data[CTRL_WAKE];
  wire         rd_go      = s_axi_arvalid && s_axi_arready;
  wire [31:0]  ctrl_word  = {31'h0, ctrl_enable};
  wire [31:0]  flags_word = {29'h0, watchdog_expiry_flag, powerdown_flag,
                             carry};
  wire [31:0]  stat_word  = {29'h0, unknown_seen, state == RRSE_RET2,
                             sleep_mode};
  wire [31:0]  rd_word;
  wire         rd_mapped;
  assign rd_mapped = (s_axi_araddr == ADDR_CTRL) ||
                     (s_axi_araddr == ADDR_FLAGS) ||
                     (s_axi_araddr == ADDR_STAT);
  assign rd_word   = (s_axi_araddr == ADDR_CTRL)  ? ctrl_word  :
                     (s_axi_araddr == ADDR_FLAGS) ? flags_word :
                     (s_axi_araddr == ADDR_STAT)  ? stat_word  : 32'h0;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      RRSE_RUN: begin
        if (do_ret) begin
          next_state = RRSE_RET2;
        end else if (do_pdown) begin
          next_state = RRSE_SLEEP;
        end
      end
      RRSE_RET2: begin
        next_state = RRSE_RUN;
      end
      RRSE_SLEEP: begin
        if (wake_event || sw_wake) begin
          next_state = RRSE_RUN;
        end
      end
      default: begin
        next_state = RRSE_RUN;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= RRSE_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------
  // Datapath outputs
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      file_we    <= 1'b0;
      file_wdata <= 8'h00;
      w_we       <= 1'b0;
      w_wdata    <= 8'h00;
    end else begin
      file_we    <= do_rot && (dest == DEST_F);
      w_we       <= do_rot && (dest == DEST_W);
      if (do_rot) begin
        file_wdata <= rot_res[7:0];
        w_wdata    <= rot_res[7:0];
      end
    end
  end

  // Return: pop now, load PC at the end of the second cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stack_pop <= 1'b0;
      pc_load   <= 1'b0;
      pc_value  <= 13'h0000;
    end else begin
      stack_pop <= do_ret;
      pc_load   <= state == RRSE_RET2;
      if (do_ret) begin
        pc_value <= stack_top_entry;
      end
    end
  end

  // Power-down side effects
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_clear <= 1'b0;
      sleep_mode     <= 1'b0;
    end else begin
      watchdog_clear <= do_pdown;
      sleep_mode     <= next_state == RRSE_SLEEP;
    end
  end

  // ------------------------------------------------------------
  // Flags; instruction effects win over software writes
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      carry                <= FLAGS_RST[FLAG_CARRY];
      powerdown_flag       <= FLAGS_RST[FLAG_PD];
      watchdog_expiry_flag <= FLAGS_RST[FLAG_TO];
      unknown_seen         <= 1'b0;
      ctrl_enable          <= CTRL_ENABLE_RST;
    end else begin
      if (do_rot) begin
        carry <= rot_res[8];
      end else if (wr_flags) begin
        carry <= w_data[FLAG_CARRY];
      end
      if (do_pdown) begin
        powerdown_flag       <= 1'b0;
        watchdog_expiry_flag <= 1'b1;
      end else if (wr_flags) begin
        powerdown_flag       <= w_data[FLAG_PD];
        watchdog_expiry_flag <= w_data[FLAG_TO];
      end
      if (do_unknown) begin
        unknown_seen <= 1'b1;
      end else if (wr_flags) begin
        unknown_seen <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl_enable <= w_data[CTRL_ENABLE];
      end
    end
  end

  // ------------------------------------------------------------
  // AXI4-Lite channels
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 4'h0;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RESP_OKAY;
    end else begin
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// >>> dv/rrse_props.sv
// Assertions on the instruction side of the execute block.
// Assumes binding into rrse_core; sees only that module's ports.
`timescale 1ns/1ps
module rrse_props
  import rrse_pkg::*;
(
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        instr_valid,
  input wire logic [13:0] instr_word,
  input wire logic        instr_ready,
  input wire logic [6:0]  file_addr,
  input wire logic [7:0]  file_rdata,
  input wire logic        file_we,
  input wire logic [7:0]  file_wdata,
  input wire logic        w_we,
  input wire logic [7:0]  w_wdata,
  input wire logic [12:0] stack_top_entry,
  input wire logic        stack_pop,
  input wire logic        pc_load,
  input wire logic [12:0] pc_value,
  input wire logic        watchdog_clear,
  input wire logic        sleep_mode,
  input wire logic        osc_halt,
  input wire logic        wake_event
);
  import rrse_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  wire take    = instr_valid && instr_ready;
  wire t_ret   = take && (instr_word == OP_RETURN);
  wire t_pd    = take && (instr_word == OP_POWERDOWN);
  wire t_rr    = take && (instr_word[OPC_HI:OPC_LO] == OP_ROT_RIGHT);
  wire t_rl    = take && (instr_word[OPC_HI:OPC_LO] == OP_ROT_LEFT);
  wire t_rot   = t_rr || t_rl;
  wire to_file = instr_word[DEST_BIT];

  ret_pop_a: assert property (t_ret |=> stack_pop && !instr_ready)
    else $error("return did not pop or did not block");
  ret_pc_a: assert property (t_ret |-> ##2 pc_load
    && pc_value == $past(stack_top_entry, 2))
    else $error("return did not load stack top two cycles on");
  rot_file_a: assert property (t_rot && to_file |=> file_we && !w_we)
    else $error("rotate with d=1 missed the file write");
  rot_w_a: assert property (t_rot && !to_file |=> w_we && !file_we)
    else $error("rotate with d=0 missed the working write");
  rr_data_a: assert property (t_rr |=> w_wdata == file_wdata
    && file_wdata[6:0] == $past(file_rdata[7:1]))
    else $error("right rotate result wrong");
  rl_data_a: assert property (t_rl |=>
    file_wdata[7:1] == $past(file_rdata[6:0]))
    else $error("left rotate result wrong");
  rot_addr_a: assert property (instr_valid |->
    file_addr == instr_word[6:0])
    else $error("file address not taken from low bits");
  pd_sleep_a: assert property (t_pd |=> watchdog_clear
    && sleep_mode && osc_halt)
    else $error("power-down side effects missing");
  sleep_hold_a: assert property (sleep_mode && !wake_event |=>
    sleep_mode && osc_halt && !instr_ready)
    else $error("sleep left without a wake event");

  cover property (t_ret ##2 pc_load);
  cover property (t_pd ##1 sleep_mode);
  cover property (t_rr ##1 t_rl);
endmodule

bind rrse_core rrse_props i_props (
  .clock(clock), .resetn(resetn), .instr_valid(instr_valid),
  .instr_word(instr_word), .instr_ready(instr_ready),
  .file_addr(file_addr), .file_rdata(file_rdata), .file_we(file_we),
  .file_wdata(file_wdata), .w_we(w_we), .w_wdata(w_wdata),
  .stack_top_entry(stack_top_entry), .stack_pop(stack_pop),
  .pc_load(pc_load), .pc_value(pc_value),
  .watchdog_clear(watchdog_clear), .sleep_mode(sleep_mode),
  .osc_halt(osc_halt), .wake_event(wake_event));

// >>> dv/rrse_file_model.sv
// Behavioural file register bank seen by the execute block.
// Assumes the write target is the address offered at accept time.
`timescale 1ns/1ps
module rrse_file_model (
  input wire logic        clock,
  input wire logic        take,
  input wire logic [6:0]  file_addr,
  input wire logic        file_we,
  input wire logic [7:0]  file_wdata,
  output logic [7:0]      file_rdata
);
  logic [7:0] mem [128];
  logic [6:0] wr_addr;
  assign file_rdata = mem[file_addr];
  always @(posedge clock) begin
    if (take) begin
      wr_addr <= file_addr;
    end
    if (file_we) begin
      mem[wr_addr] <= file_wdata;
    end
  end
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the return/rotate/power-down execute block.
// Assumes rrse_core with its bound checker and the file model.
`timescale 1ns/1ps
module testbench;
  import rrse_pkg::*;
  logic        clock, resetn, instr_valid, instr_ready, file_we, w_we;
  logic        stack_pop, pc_load, watchdog_clear, sleep_mode, osc_halt;
  logic        wake_event, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [13:0] instr_word;
  logic [12:0] stack_top_entry, pc_value;
  logic [6:0]  file_addr;
  logic [7:0]  file_rdata, file_wdata, w_wdata;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          fails, n_checks;

  rrse_core i_dut (.clock(clock), .resetn(resetn),
    .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_ready(instr_ready), .file_addr(file_addr),
    .file_rdata(file_rdata), .file_we(file_we), .file_wdata(file_wdata),
    .w_we(w_we), .w_wdata(w_wdata), .stack_top_entry(stack_top_entry),
    .stack_pop(stack_pop), .pc_load(pc_load), .pc_value(pc_value),
    .watchdog_clear(watchdog_clear), .sleep_mode(sleep_mode),
    .osc_halt(osc_halt), .wake_event(wake_event),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  rrse_file_model i_model (.clock(clock),
    .take(instr_valid && instr_ready), .file_addr(file_addr),
    .file_we(file_we), .file_wdata(file_wdata), .file_rdata(file_rdata));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ad, wd;
    @(posedge clock);
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clock);
      if (s_axi_awready && !ad) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !wd) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    // Let an edge pass so back-to-back calls never drive twice at once
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk(s_axi_rresp, er);
  endtask

  // Offer one word; keep holds valid up for a back-to-back successor
  task automatic ex(input logic [13:0] w, input bit keep);
    instr_word <= w;
    instr_valid <= 1'b1;
    do @(posedge clock); while (!instr_ready);
    if (!keep) begin
      instr_valid <= 1'b0;
      instr_word <= ~w;
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #20000;
    fails++;
    print_verdict();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {resetn, instr_valid, wake_event, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {instr_word, stack_top_entry, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hf;
    fails = 0;
    n_checks = 0;
    i_model.mem[16] = 8'he6;
    i_model.mem[127] = 8'h00;
    i_model.mem[0] = 8'h80;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    repeat (3) @(posedge clock);
    rd(ADDR_CTRL, 32'h1, RESP_OKAY);
    rd(ADDR_FLAGS, 32'h6, RESP_OKAY);
    rd(4'hc, 32'h0, RESP_SLVERR);
    wr(4'hc, 32'hff, RESP_SLVERR);
    ex(14'h0c10, 0);
    repeat (2) @(posedge clock);
    chk(w_wdata, 8'h73);
    chk(i_model.mem[16], 8'he6);
    rd(ADDR_FLAGS, 32'h6, RESP_OKAY);
    ex(14'h0d90, 0);
    repeat (2) @(posedge clock);
    chk(i_model.mem[16], 8'hcc);
    rd(ADDR_FLAGS, 32'h7, RESP_OKAY);
    ex(14'h0cff, 1);
    ex(14'h0d00, 0);
    repeat (2) @(posedge clock);
    chk(i_model.mem[127], 8'h80);
    chk(w_wdata, 8'h00);
    rd(ADDR_FLAGS, 32'h7, RESP_OKAY);
    wr(ADDR_FLAGS, 32'h1, RESP_OKAY);
    stack_top_entry <= 13'h1abc;
    @(posedge clock);
    ex(OP_RETURN, 0);
    stack_top_entry <= 13'h0555;
    @(posedge clock);
    chk(stack_pop, 1'b1);
    repeat (2) @(posedge clock);
    chk(pc_value, 13'h1abc);
    rd(ADDR_FLAGS, 32'h1, RESP_OKAY);
    ex(OP_POWERDOWN, 0);
    @(posedge clock);
    chk(watchdog_clear, 1'b1);
    @(posedge clock);
    chk(sleep_mode, 1'b1);
    chk(instr_ready, 1'b0);
    rd(ADDR_FLAGS, 32'h5, RESP_OKAY);
    rd(ADDR_STAT, 32'h1, RESP_OKAY);
    wake_event <= 1'b1;
    @(posedge clock);
    wake_event <= 1'b0;
    repeat (2) @(posedge clock);
    chk(osc_halt, 1'b0);
    ex(14'h3fff, 0);
    rd(ADDR_STAT, 32'h4, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0, RESP_OKAY);
    @(posedge clock);
    chk(instr_ready, 1'b0);
    wr(ADDR_CTRL, 32'h1, RESP_OKAY);
    print_verdict();
  end
endmodule
